/* core/pwm_timer_defs.svh */
// Constants for the cascaded PWM timer channel: addresses, field positions, codes, resets.
// Assumes a 24-bit byte address and 16-bit data on the register port.
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH
`define ADDR_PIN_FUNC   24'hfffbc9
`define ADDR_CNT_CTRL   24'hfffee0
`define ADDR_MODE       24'hfffee1
`define ADDR_IO_CTRL    24'hfffee2
`define ADDR_COUNTER    24'hfffee6
`define ADDR_FIRST_GR   24'hfffee8
`define ADDR_SECOND_GR  24'hfffeea
`define ADDR_START      24'hffffbc
`define PIN_MUX_BIT     6
`define START_BIT       4
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define CLEAR_ON_FIRST  3'h1
`define CLEAR_ON_SECOND 3'h2
`define EDGE_FALL       2'h0
`define EDGE_RISE       2'h1
`define PRESC_INTERNAL  3'h0
`define PRESC_CASCADE   3'h7
`define MODE_PWM1       4'h2
`endif

/* core/pwm_timer_pkg.sv */
// Types shared by the cascaded PWM timer channel.
// Assumes the constants header is compiled alongside.
`default_nettype none
package pwm_timer_pkg;
  typedef struct packed {
    logic [2:0] clear_sel;
    logic [1:0] edge_sel;
    logic [2:0] presc;
  } counter_ctrl_t;
  typedef struct packed {
    logic [3:0] second;
    logic [3:0] first;
  } io_ctrl_t;
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_t;
endpackage
`default_nettype wire

/* core/cascaded_pwm_timer_channel.sv */
// One 16-bit timer channel in PWM mode 1, countable from the neighbour's overflow.
// Assumes a single-cycle register port and a neighbour overflow level on core_clk.
// Software must configure while the counter is stopped; a select change can fake a capture edge.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "pwm_timer_defs.svh"
`default_nettype none
module cascaded_pwm_timer_channel (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic [23:0]               addr,
  input  wire logic [15:0]               wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output var  logic [15:0]               rdata,
  input  wire logic                      neighbour_overflow,
  input  wire logic                      primary_port_pin_in,
  input  wire logic                      alternate_port_pin_in,
  output var  pwm_timer_pkg::pin_drive_t pwm_output_pin
);
  import pwm_timer_pkg::*;

  // Compare action: 00 keep, 01 low, 10 high, 11 toggle.
  function automatic logic act(input logic [1:0] a, input logic cur);
    case (a)
      2'h1:    act = 1'b0;
      2'h2:    act = 1'b1;
      2'h3:    act = ~cur;
      default: act = cur;
    endcase
  endfunction

  // A field drives the pin when it is a compare code other than disabled.
  function automatic logic is_cmp(input logic [3:0] f);
    is_cmp = (f[3] == 1'b0) && (f != 4'h0);
  endfunction

  // State registers with their next values, then the combinational decode nets.
  logic [7:0]    pfc_reg, pfc_next;
  counter_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0]    mode_reg, mode_next;
  io_ctrl_t      io_reg, io_next;
  logic          start_reg, start_next;
  logic [15:0]   cnt_reg, cnt_next;
  logic [15:0]   gra_reg, gra_next;
  logic [15:0]   grb_reg, grb_next;
  logic          ovf_prev_reg, ovf_prev_next;
  logic [1:0][2:0] sync_reg, sync_next;
  logic [1:0]    filt_reg, filt_next;
  logic          cap_prev_reg, cap_prev_next;
  pin_drive_t    pin_reg, pin_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic          pin_sel, pwm1, cap_mode, cap_in, cap;
  logic          fall, rise, tick, match_a, match_b, clear_hit;

  // Pin synchronisers; a level counts only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sync_next[i] = {sync_reg[i][1:0], (i == 0) ? primary_port_pin_in : alternate_port_pin_in};
      filt_next[i] = (sync_reg[i][1] == sync_reg[i][2]) ? sync_reg[i][2] : filt_reg[i];
    end
  end

  // Count source, edge choice and compare events.
  always_comb begin
    pin_sel  = pfc_reg[`PIN_MUX_BIT];
    pwm1     = (mode_reg[3:0] == `MODE_PWM1);
    cap_mode = io_reg.second[3];
    cap_in   = pin_sel ? filt_reg[1] : filt_reg[0];
    cap      = cap_mode && cap_in && !cap_prev_reg;
    cap_prev_next = cap_in;
    ovf_prev_next = neighbour_overflow;
    fall = ovf_prev_reg && !neighbour_overflow;
    rise = !ovf_prev_reg && neighbour_overflow;
    // Unlisted prescaler codes leave tick low, so the counter simply stops.
    tick = 1'b0;
    if (start_reg) begin
      if (ctrl_reg.presc == `PRESC_INTERNAL) begin
        tick = 1'b1;
      end else if (ctrl_reg.presc == `PRESC_CASCADE) begin
        case (ctrl_reg.edge_sel)
          `EDGE_FALL: tick = fall;
          `EDGE_RISE: tick = rise;
          default:    tick = fall || rise;
        endcase
      end
    end
    // A capture-mode second register never compares, so it cannot also clear on a match.
    match_a = tick && (cnt_reg == gra_reg);
    match_b = tick && !cap_mode && (cnt_reg == grb_reg);
    clear_hit = ((ctrl_reg.clear_sel == `CLEAR_ON_SECOND) && (match_b || cap))
             || ((ctrl_reg.clear_sel == `CLEAR_ON_FIRST) && match_a);
  end

  // Register writes, counter, capture and read data.
  always_comb begin
    pfc_next   = pfc_reg;
    ctrl_next  = ctrl_reg;
    mode_next  = mode_reg;
    io_next    = io_reg;
    start_next = start_reg;
    gra_next   = gra_reg;
    grb_next   = cap ? cnt_reg : grb_reg;
    cnt_next   = cnt_reg;
    if (clear_hit) begin
      cnt_next = `RST_WORD;
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    // A software write wins over counting in the same cycle.
    // 8-bit registers take the low byte, the mode register only its low nibble; their upper bits read back as zero.
    if (wr_stb) begin
      case (addr)
        `ADDR_PIN_FUNC:  pfc_next   = wdata[7:0];
        `ADDR_CNT_CTRL:  ctrl_next  = wdata[7:0];
        `ADDR_MODE:      mode_next  = {4'h0, wdata[3:0]};
        `ADDR_IO_CTRL:   io_next    = wdata[7:0];
        `ADDR_START:     start_next = wdata[`START_BIT];
        `ADDR_COUNTER:   cnt_next   = wdata;
        `ADDR_FIRST_GR:  gra_next   = wdata;
        `ADDR_SECOND_GR: grb_next   = wdata;
        default:         ;
      endcase
    end
    // Read data is zero outside the cycle after a read, so an OR of several slaves stays clean.
    rdata_next = `RST_WORD;
    if (rd_stb) begin
      case (addr)
        `ADDR_PIN_FUNC:  rdata_next = {8'h00, pfc_reg};
        `ADDR_CNT_CTRL:  rdata_next = {8'h00, ctrl_reg};
        `ADDR_MODE:      rdata_next = {8'h00, mode_reg};
        `ADDR_IO_CTRL:   rdata_next = {8'h00, io_reg};
        `ADDR_START:     rdata_next = {11'h000, start_reg, 4'h0};
        `ADDR_COUNTER:   rdata_next = cnt_reg;
        `ADDR_FIRST_GR:  rdata_next = gra_reg;
        `ADDR_SECOND_GR: rdata_next = grb_reg;
        default:         rdata_next = `RST_WORD;
      endcase
    end
  end

  // Output pin. The first compare output, and in PWM mode 1 the second, land on the primary pin whatever the select bit says.
  always_comb begin
    pin_next = pin_reg;
    // A control write sets the initial level and enables the driver for any compare code other than disabled.
    if (wr_stb && (addr == `ADDR_IO_CTRL)) begin
      pin_next.level = wdata[2];
      pin_next.oe    = is_cmp(wdata[3:0]);
    end else begin
      if (match_a) begin
        pin_next.level = act(io_reg.first[1:0], pin_reg.level);
      end
      // In PWM mode 1 the second register shapes the same pin and wins a tie.
      if (pwm1 && match_b) begin
        pin_next.level = act(io_reg.second[1:0], pin_next.level);
      end
    end
  end

  // Pin synchroniser stages and the filtered levels taken from them.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_reg <= 6'h00;
      filt_reg <= 2'h0;
    end else begin
      sync_reg <= sync_next;
      filt_reg <= filt_next;
    end
  end

  // Edge detector history; both start at the idle low level so no false edge follows reset.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ovf_prev_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      ovf_prev_reg <= ovf_prev_next;
      cap_prev_reg <= cap_prev_next;
    end
  end

  // Software registers, counter, general registers and read data.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pfc_reg   <= `RST_BYTE;
      ctrl_reg  <= `RST_BYTE;
      mode_reg  <= `RST_BYTE;
      io_reg    <= `RST_BYTE;
      start_reg <= 1'b0;
      cnt_reg   <= `RST_WORD;
      gra_reg   <= `RST_WORD;
      grb_reg   <= `RST_WORD;
      rdata_reg <= `RST_WORD;
    end else begin
      pfc_reg   <= pfc_next;
      ctrl_reg  <= ctrl_next;
      mode_reg  <= mode_next;
      io_reg    <= io_next;
      start_reg <= start_next;
      cnt_reg   <= cnt_next;
      gra_reg   <= gra_next;
      grb_reg   <= grb_next;
      rdata_reg <= rdata_next;
    end
  end

  // Output pin drive.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_reg <= 2'h0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // Outputs come straight from their flip-flops.
  assign rdata          = rdata_reg;
  assign pwm_output_pin = pin_reg;

  // Every check runs on the core clock and stands down while reset is high.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Conditions shared by the cascade, capture and PWM checks.
  sequence s_cascade_fall;
    start_reg && !wr_stb && ctrl_reg.presc == `PRESC_CASCADE && ctrl_reg.edge_sel == `EDGE_FALL;
  endsequence
  sequence s_clear_b_cap;
    !wr_stb && cap_mode && ctrl_reg.clear_sel == `CLEAR_ON_SECOND && !cap_prev_reg;
  endsequence
  sequence s_pwm_quiet;
    pwm1 && !wr_stb;
  endsequence

  // Capture routing by the select bit, the bit's position, the clear on the second match, cascade edge counting and PWM pin levels.
  a_primary_capture: assert property (s_clear_b_cap and (!pin_sel && filt_reg[0]) |=> cnt_reg == 16'h0000)
    else $error("primary capture did not clear");
  a_alt_capture: assert property (s_clear_b_cap and (pin_sel && filt_reg[1]) |=> cnt_reg == 16'h0000)
    else $error("alternate capture did not clear");
  a_mux_bit: assert property (wr_stb && addr == `ADDR_PIN_FUNC |=> pin_sel == $past(wdata[6]))
    else $error("pin select not at bit 6");
  a_clear_on_b: assert property (!wr_stb && match_b && ctrl_reg.clear_sel == `CLEAR_ON_SECOND |=> cnt_reg == 0)
    else $error("counter not cleared on second match");
  a_fall_count: assert property (s_cascade_fall and ($fell(neighbour_overflow) && !clear_hit)
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("no count on neighbour falling edge");
  a_no_rise_count: assert property (s_cascade_fall and $rose(neighbour_overflow) |=> $stable(cnt_reg))
    else $error("counted on rising edge");
  a_rise_on_first: assert property (s_pwm_quiet and (match_a && !match_b && io_reg.first == 4'h2)
    |=> pin_reg.level ##1 1'b1)
    else $error("output not high after first match");
  a_fall_on_second: assert property (s_pwm_quiet and (match_b && io_reg.second == 4'h5) |=> !pin_reg.level)
    else $error("output not low after second match");
  a_initial_low: assert property (wr_stb && addr == `ADDR_IO_CTRL && wdata[3:0] == 4'h2
    |=> !pin_reg.level && pin_reg.oe)
    else $error("initial level not low");

  // Register port: read data stands only in the cycle after a read, and writes land at the strobe edge.
  a_rdata_idle: assert property (!rd_stb |=> rdata_reg == 16'h0000)
    else $error("read data not zero outside a read");
  a_read_first: assert property (rd_stb && addr == `ADDR_FIRST_GR |=> rdata_reg == $past(gra_reg))
    else $error("first register read back wrong");
  a_read_second: assert property (rd_stb && addr == `ADDR_SECOND_GR |=> rdata_reg == $past(grb_reg))
    else $error("second register read back wrong");
  a_read_counter: assert property (rd_stb && addr == `ADDR_COUNTER |=> rdata_reg == $past(cnt_reg))
    else $error("counter read back wrong");
  a_read_io: assert property (rd_stb && addr == `ADDR_IO_CTRL |=> rdata_reg == {8'h00, $past(io_reg)})
    else $error("control register read back wrong");
  a_write_first: assert property (wr_stb && addr == `ADDR_FIRST_GR |=> gra_reg == $past(wdata))
    else $error("first register write lost");
  a_write_second: assert property (wr_stb && addr == `ADDR_SECOND_GR |=> grb_reg == $past(wdata))
    else $error("second register write lost");
  a_write_counter: assert property (wr_stb && addr == `ADDR_COUNTER |=> cnt_reg == $past(wdata))
    else $error("counter write lost");
  a_start_bit: assert property (wr_stb && addr == `ADDR_START |=> start_reg == $past(wdata[`START_BIT]))
    else $error("start bit write lost");
  a_mode_nibble: assert property (wr_stb && addr == `ADDR_MODE |=> mode_reg == {4'h0, $past(wdata[3:0])})
    else $error("mode register kept upper bits");

  // Counting: a stopped counter holds, the internal clock advances it every cycle, and a cascaded
  // counter holds while the neighbour level is steady. Captures are left out because they may clear.
  sequence s_no_capture;
    !wr_stb && !cap;
  endsequence
  a_stopped_hold: assert property (s_no_capture and !start_reg |=> $stable(cnt_reg))
    else $error("stopped counter moved");
  a_internal_count: assert property (s_no_capture and (start_reg && !clear_hit
    && ctrl_reg.presc == `PRESC_INTERNAL) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("internal clock did not advance counter");
  a_cascade_idle: assert property (s_cascade_fall and ($stable(neighbour_overflow) && !cap)
    |=> $stable(cnt_reg))
    else $error("cascaded counter moved without neighbour edge");

  // Capture and pin: a capture copies the counter, the level holds between events, and
  // the select bit never moves the compare output off the primary pin.
  sequence s_capture_edge;
    !wr_stb && cap_mode && cap_in && !cap_prev_reg;
  endsequence
  sequence s_no_pin_event;
    !match_a && !(pwm1 && match_b) && !(wr_stb && addr == `ADDR_IO_CTRL);
  endsequence
  a_capture_copy: assert property (s_capture_edge |=> grb_reg == $past(cnt_reg))
    else $error("capture did not copy counter");
  a_level_hold: assert property (s_no_pin_event |=> $stable(pin_reg.level))
    else $error("pin level moved without a match");
  a_sel_keeps_pin: assert property (s_no_pin_event and (wr_stb && addr == `ADDR_PIN_FUNC)
    |=> $stable(pin_reg))
    else $error("select write moved the output");
endmodule
`default_nettype wire

/* verif/pwm_pin_load.sv */
// Load on the primary pin: it reads back what the channel drives.
// Assumes the pin drive struct of the timer package and the bench clock.
`timescale 1ns/10ps
`default_nettype none
module pwm_pin_load (
  input  wire logic                      core_clk,
  input  wire pwm_timer_pkg::pin_drive_t drive,
  output var  logic                      pin
);
  import pwm_timer_pkg::*;
  logic pat = 1'b0;
  // A released pin floats, so it shows a changing pattern rather than a stale level.
  always @(posedge core_clk) begin
    pat <= ~pat;
  end
  // The wire follows the driver only while the output enable is high.
  assign pin = drive.oe ? drive.level : pat;
endmodule
`default_nettype wire

/* verif/cascaded_pwm_timer_channel_tb_top.sv */
// Self-checking bench for the cascaded PWM timer channel.
// Assumes the package, the constants header and the pin load are compiled first.
`timescale 1ns/10ps
`include "pwm_timer_defs.svh"
`default_nettype none
module cascaded_pwm_timer_channel_tb_top;
  import pwm_timer_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [23:0] addr     = 24'h000000;
  logic [15:0] wdata    = 16'h0000;
  logic        wr_stb   = 1'b0;
  logic        rd_stb   = 1'b0;
  logic        nov      = 1'b0;
  logic        alt_pin  = 1'b0;
  logic [15:0] rdata;
  logic        prim_pin;
  pin_drive_t  pin;
  logic [15:0] d;
  logic [31:0] r;
  logic [31:0] rs       = 32'd29;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          f, s, k, hi;
  logic [23:0] map [8] = '{`ADDR_PIN_FUNC, `ADDR_CNT_CTRL, `ADDR_MODE, `ADDR_IO_CTRL,
                           `ADDR_COUNTER, `ADDR_FIRST_GR, `ADDR_SECOND_GR, `ADDR_START};
  cascaded_pwm_timer_channel i_dut (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .neighbour_overflow(nov),
    .primary_port_pin_in(prim_pin), .alternate_port_pin_in(alt_pin), .pwm_output_pin(pin));
  pwm_pin_load i_load (.core_clk(core_clk), .drive(pin), .pin(prim_pin));
  // Clock at 25 MHz.
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // High cycles in n whole periods: from the first match to the second.
  function automatic int exp_high(input int f, input int s, input int n);
    return n * (s - f);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // Each access leaves a quiet cycle, so no strobe is assigned twice in one step.
  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [23:0] a);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask
  // The pulse outlasts the input synchroniser by a margin.
  task automatic pulse();
    alt_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    alt_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take.
  initial begin
    #(40 * 20000);
    n_mismatch++;
    results();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rd(map[i]);
      chk(d, `RST_WORD, "reset value");
    end
    wr(24'hfffee4, 16'h1234);
    rd(24'hfffee4);
    chk(d, 16'h0000, "unmapped read");
    wr(`ADDR_MODE, 16'h00f2);
    rd(`ADDR_MODE);
    chk(d, 16'h0002, "mode field");
    // Random periods; everything is set while stopped, then started.
    for (int t = 0; t < 3; t++) begin
      r = rnd();
      f = r % 5;
      r = rnd();
      s = f + 1 + r % 5;
      wr(`ADDR_START, 16'h0000);
      wr(`ADDR_COUNTER, 16'h0000);
      wr(`ADDR_CNT_CTRL, 16'h0040);
      wr(`ADDR_FIRST_GR, f[15:0]);
      wr(`ADDR_SECOND_GR, s[15:0]);
      wr(`ADDR_IO_CTRL, 16'h0052);
      #1 chk({14'h0, pin.level, pin.oe}, 16'h0001, "initial level");
      @(posedge core_clk);
      wr(`ADDR_START, 16'h0010);
      repeat (2 * (s + 1)) @(posedge core_clk);
      hi = 0;
      repeat (3 * (s + 1)) begin
        @(posedge core_clk);
        #1 if (pin.level === 1'b1) hi++;
      end
      chk(hi[15:0], 16'(exp_high(f, s, 3)), "high time");
      @(posedge core_clk);
    end
    // Cascade: count falling edges of the neighbour overflow.
    wr(`ADDR_START, 16'h0000);
    wr(`ADDR_COUNTER, 16'h0000);
    wr(`ADDR_CNT_CTRL, 16'h0047);
    wr(`ADDR_FIRST_GR, 16'h00ff);
    wr(`ADDR_SECOND_GR, 16'h03ff);
    wr(`ADDR_START, 16'h0010);
    k = 0;
    repeat (60) begin
      r = rnd();
      if (nov && !r[0]) k++;
      nov <= r[0];
      @(posedge core_clk);
    end
    if (nov) k++;
    nov <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(`ADDR_START, 16'h0000);
    rd(`ADDR_COUNTER);
    chk(d, k[15:0], "cascade count");
    // Capture source follows the select bit.
    wr(`ADDR_PIN_FUNC, 16'h0040);
    rd(`ADDR_PIN_FUNC);
    chk(d, 16'h0040, "select bit");
    wr(`ADDR_CNT_CTRL, 16'h0040);
    wr(`ADDR_IO_CTRL, 16'h0082);
    wr(`ADDR_COUNTER, 16'h0055);
    pulse();
    rd(`ADDR_SECOND_GR);
    chk(d, 16'h0055, "alternate capture");
    rd(`ADDR_COUNTER);
    chk(d, 16'h0000, "capture clear");
    wr(`ADDR_PIN_FUNC, 16'h0000);
    wr(`ADDR_COUNTER, 16'h0066);
    pulse();
    rd(`ADDR_SECOND_GR);
    chk(d, 16'h0055, "alternate ignored");
    rd(`ADDR_COUNTER);
    chk(d, 16'h0066, "no clear");
    // Raising the driven level by a control write loops back through the shared primary pin.
    wr(`ADDR_IO_CTRL, 16'h0086);
    repeat (6) @(posedge core_clk);
    rd(`ADDR_SECOND_GR);
    chk(d, 16'h0066, "primary capture");
    rd(`ADDR_COUNTER);
    chk(d, 16'h0000, "primary clear");
    // A second reset in mid-run returns the registers and the pin to zero.
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1 chk({14'h0, pin.level, pin.oe}, 16'h0000, "pin after reset");
    rd(`ADDR_IO_CTRL);
    chk(d, `RST_WORD, "control after reset");
    rd(`ADDR_SECOND_GR);
    chk(d, `RST_WORD, "second after reset");
    results();
  end
endmodule
`default_nettype wire
